// ==== core/mc_error_log.sv ====
// Memory controller error-log banks 9..16, status and misc per bank
// Function
// RULE1: Eight banks numbered nine to sixteen
// RULE2: Control bit one enables extended logging
// RULE3: Status 15:0 holds bus-format error code
// RULE4: Codes 0x001 address, 0x002 write data
// RULE5: Code 0x004 write byte-enable parity
// RULE6: Codes 0x008/0x010 patrol scrub errors
// RULE7: Codes 0x020/0x040 spare errors
// RULE8: Code 0x100 buffer parity, others reserved
// RULE9: Status 36:32 first failing device id
// RULE10: Misc 13:9 buffer entry on parity
// RULE11: Misc 13:9 second device on read
// RULE12: Misc 29:14 first device bit mask
// RULE13: Misc 45:30 second device bit mask
// RULE14: Misc 50:46 first device failing rank
// RULE15: Misc 55:51 second device failing rank
// RULE16: Misc 62 flags first device capture
// RULE17: Misc 63 flags second device capture
// RULE18: Software trusts second only with first
// RULE19: Extended fields stay clear when disabled
// RULE20: Validity bits architectural, reserved read zero
module mc_error_log
   import mc_error_log_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   input wire logic [63:0] i_error_logging_control,
   input wire logic i_err_valid,
   input wire logic [2:0] i_err_bank,
   input wire err_kind_e i_err_kind,
   input wire logic [1:0] i_err_pp,
   input wire logic i_err_t,
   input wire logic [3:0] i_err_rrrr,
   input wire logic [1:0] i_err_ii,
   input wire logic [1:0] i_err_ll,
   input wire logic [8:0] i_err_addr_info,
   input wire logic [18:0] i_err_arch_info,
   input wire logic [6:0] i_err_validity,
   input wire logic [4:0] i_err_device,
   input wire logic [15:0] i_err_bit_mask,
   input wire logic [4:0] i_err_rank,
   input wire logic [4:0] i_err_wdb_id,
   input wire logic i_rd_en,
   input wire logic [4:0] i_rd_index,
   input wire logic i_clr_en,
   input wire logic [2:0] i_clr_bank,
   output logic [63:0] o_rd_data,
   output logic o_rd_valid
);
   typedef struct packed {
      logic [BANK_COUNT-1:0][63:0] status;
      logic [BANK_COUNT-1:0][63:0] misc;
      logic [63:0] rd_data;
      logic rd_valid;
   } state_s;

   state_s state_reg;
   state_s state_next;

   // Maps a bank number 9..16 to its slot, flags numbers out of range
   function automatic logic [3:0] bank_slot(input logic [4:0] num);
      logic [4:0] off;
      off = num - 5'(FIRST_BANK_NUMBER);
      if (num >= 5'(FIRST_BANK_NUMBER) && num <= 5'(LAST_BANK_NUMBER))
         bank_slot = {1'b0, off[2:0]};
      else
         bank_slot = 4'h8;
   endfunction : bank_slot

   function automatic logic [15:0] model_code(input err_kind_e kind);
      case (kind)
         // RULE4: address and write data parity
         EV_ADDR_PARITY: model_code = MS_ADDR_PARITY;
         EV_HA_WDATA_PARITY: model_code = MS_HA_WDATA_PARITY;
         // RULE5: byte-enable parity
         EV_HA_WBE_PARITY: model_code = MS_HA_WBE_PARITY;
         // RULE6: patrol scrub codes
         EV_PATROL_CORR: model_code = MS_PATROL_CORR;
         EV_PATROL_UNCORR: model_code = MS_PATROL_UNCORR;
         // RULE7: spare codes
         EV_SPARE_CORR: model_code = MS_SPARE_CORR;
         EV_SPARE_UNCORR: model_code = MS_SPARE_UNCORR;
         // RULE8: buffer parity, reserved otherwise
         EV_WDB_PARITY: model_code = MS_WDB_PARITY;
         default: model_code = 16'h0000;
      endcase
   endfunction : model_code

   logic ext_log;
   assign ext_log = i_error_logging_control[CTRL_EXT_LOG_BIT];

   always_comb
   begin
      logic [63:0] st;
      logic [63:0] mi;
      logic [3:0] slot;
      st = 64'h0000000000000000;
      mi = 64'h0000000000000000;
      slot = 4'h0;
      state_next = state_reg;
      state_next.rd_valid = 1'b0;
      if (i_clr_en)
      begin
         state_next.status[i_clr_bank] = REG_RESET;
         state_next.misc[i_clr_bank] = REG_RESET;
      end
      // RULE1: one capture per bank, capture beats clear
      if (i_err_valid)
      begin
         st = state_next.status[i_err_bank];
         mi = state_next.misc[i_err_bank];
         // RULE3: bus error format code
         st[ST_CODE_MSB:ST_CODE_LSB] = {1'h0, BUS_CODE_TOP, i_err_pp, i_err_t,
                                       i_err_rrrr, i_err_ii, i_err_ll};
         st[ST_MODEL_MSB:ST_MODEL_LSB] = model_code(i_err_kind);
         st[ST_ARCH_MSB:ST_ARCH_LSB] = i_err_arch_info;
         // RULE20: validity indicators, reserved zero
         st[ST_VALID_MSB:ST_VALID_LSB] = i_err_validity;
         st[ST_RSVD_BIT] = 1'b0;
         mi[MI_ADDR_MSB:MI_ADDR_LSB] = i_err_addr_info;
         // RULE10: buffer entry on write parity
         if (i_err_kind == EV_HA_WDATA_PARITY || i_err_kind == EV_HA_WBE_PARITY)
            mi[MI_ID_MSB:MI_ID_LSB] = i_err_wdb_id;
         // RULE2: extended capture only when enabled
         if (ext_log && i_err_kind == EV_CORR_READ)
         begin
            if (!mi[MI_VALID1_BIT])
            begin
               // RULE9: first device id
               st[ST_DEV_MSB:ST_DEV_LSB] = i_err_device;
               // RULE12: first mask
               mi[MI_MASK1_MSB:MI_MASK1_LSB] = i_err_bit_mask;
               // RULE14: first rank
               mi[MI_RANK1_MSB:MI_RANK1_LSB] = i_err_rank;
               // RULE16: first valid
               mi[MI_VALID1_BIT] = 1'b1;
            end
            else
            begin
               // RULE11: second device id in misc
               mi[MI_ID_MSB:MI_ID_LSB] = i_err_device;
               // RULE13: second mask
               mi[MI_MASK2_MSB:MI_MASK2_LSB] = i_err_bit_mask;
               // RULE15: second rank
               mi[MI_RANK2_MSB:MI_RANK2_LSB] = i_err_rank;
               // RULE17: second valid, only after first
               mi[MI_VALID2_BIT] = 1'b1;
            end
         end
         // RULE19: disabled clears extended fields to zero
         if (!ext_log)
         begin
            st[ST_DEV_MSB:ST_DEV_LSB] = 5'h00;
            mi[MI_MASK2_MSB:MI_MASK1_LSB] = 32'h00000000;
            mi[MI_RANK2_MSB:MI_RANK1_LSB] = 10'h000;
            mi[MI_VALID2_BIT:MI_VALID1_BIT] = 2'b00;
         end
         mi[MI_RSVD_MSB:MI_RSVD_LSB] = 6'h00;
         state_next.status[i_err_bank] = st;
         state_next.misc[i_err_bank] = mi;
      end
      // Index 0..7 picks bank 9..16 status, 8..15 read zero, bit 4 selects misc half
      if (i_rd_en)
      begin
         slot = bank_slot({1'b0, i_rd_index[3:0]} + 5'(FIRST_BANK_NUMBER));
         state_next.rd_valid = 1'b1;
         if (i_rd_index[4])
            state_next.rd_data = state_reg.misc[i_rd_index[2:0]];
         else if (slot != 4'h8)
            state_next.rd_data = state_reg.status[i_rd_index[2:0]];
         else
            state_next.rd_data = 64'h0000000000000000;
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
         state_reg <= '0;
      else
         state_reg <= state_next;
   end

   assign o_rd_data = state_reg.rd_data;
   assign o_rd_valid = state_reg.rd_valid;

   property p_first_valid; // RULE16
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_err_valid && ext_log && i_err_kind == EV_CORR_READ && !i_clr_en)
         |=> state_reg.misc[$past(i_err_bank)][MI_VALID1_BIT];
   endproperty
   a_first_valid: assert property (p_first_valid) // RULE16
      else $error("first device valid not set");

   property p_second_needs_first; // RULE17
      @(posedge i_core_clk) disable iff (!i_rst_n)
      state_reg.misc[i_err_bank][MI_VALID2_BIT] |-> state_reg.misc[i_err_bank][MI_VALID1_BIT];
   endproperty
   a_second_needs_first: assert property (p_second_needs_first) // RULE17
      else $error("second valid without first");

   property p_disabled_clear; // RULE19
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_err_valid && !ext_log)
         |=> state_reg.misc[$past(i_err_bank)][MI_VALID2_BIT:MI_VALID1_BIT] == 2'b00;
   endproperty
   a_disabled_clear: assert property (p_disabled_clear) // RULE19
      else $error("extended flags set while disabled");

   property p_code_top; // RULE3
      @(posedge i_core_clk) disable iff (!i_rst_n)
      i_err_valid |=> state_reg.status[$past(i_err_bank)][ST_CODE_LSB + 11] == 1'b1;
   endproperty
   a_code_top: assert property (p_code_top) // RULE3
      else $error("bus format marker missing");

   property p_addr_code; // RULE4
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_err_valid && i_err_kind == EV_ADDR_PARITY)
         |=> state_reg.status[$past(i_err_bank)][ST_MODEL_MSB:ST_MODEL_LSB] == 16'h0001;
   endproperty
   a_addr_code: assert property (p_addr_code) // RULE4
      else $error("address parity code wrong");

   property p_wbe_code; // RULE5
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_err_valid && i_err_kind == EV_HA_WBE_PARITY)
         |=> state_reg.status[$past(i_err_bank)][ST_MODEL_MSB:ST_MODEL_LSB] == 16'h0004;
   endproperty
   a_wbe_code: assert property (p_wbe_code) // RULE5
      else $error("byte enable parity code wrong");

   property p_patrol_code; // RULE6
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_err_valid && i_err_kind == EV_PATROL_UNCORR)
         |=> state_reg.status[$past(i_err_bank)][ST_MODEL_MSB:ST_MODEL_LSB] == 16'h0010;
   endproperty
   a_patrol_code: assert property (p_patrol_code) // RULE6
      else $error("patrol scrub code wrong");

   property p_wdb_id; // RULE10
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_err_valid && i_err_kind == EV_HA_WDATA_PARITY)
         |=> state_reg.misc[$past(i_err_bank)][MI_ID_MSB:MI_ID_LSB] == $past(i_err_wdb_id);
   endproperty
   a_wdb_id: assert property (p_wdb_id) // RULE10
      else $error("buffer entry id not captured");

   property p_rsvd_zero; // RULE20
      @(posedge i_core_clk) disable iff (!i_rst_n)
      state_reg.status[i_rd_index[2:0]][ST_RSVD_BIT] == 1'b0;
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero) // RULE20
      else $error("reserved status bit set");

   sequence s_first_capture;
      i_err_valid && ext_log && i_err_kind == EV_CORR_READ && !i_clr_en
         && !state_reg.misc[i_err_bank][MI_VALID1_BIT];
   endsequence

   sequence s_second_capture;
      i_err_valid && ext_log && i_err_kind == EV_CORR_READ && !i_clr_en
         && state_reg.misc[i_err_bank][MI_VALID1_BIT];
   endsequence

   property p_first_dev; // RULE9
      @(posedge i_core_clk) disable iff (!i_rst_n)
      s_first_capture |=> state_reg.status[$past(i_err_bank)][ST_DEV_MSB:ST_DEV_LSB]
         == $past(i_err_device);
   endproperty
   a_first_dev: assert property (p_first_dev) // RULE9
      else $error("first device id not captured");

   property p_second_id; // RULE11
      @(posedge i_core_clk) disable iff (!i_rst_n)
      s_second_capture
         |=> state_reg.misc[$past(i_err_bank)][MI_ID_MSB:MI_ID_LSB] == $past(i_err_device);
   endproperty
   a_second_id: assert property (p_second_id) // RULE11
      else $error("second device id not captured");

   property p_second_valid; // RULE17
      @(posedge i_core_clk) disable iff (!i_rst_n)
      s_second_capture
         |=> state_reg.misc[$past(i_err_bank)][MI_VALID2_BIT:MI_VALID1_BIT] == 2'b11;
   endproperty
   a_second_valid: assert property (p_second_valid) // RULE17
      else $error("second device valid not set");

   property p_wdata_code; // RULE4
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_err_valid && i_err_kind == EV_HA_WDATA_PARITY)
         |=> state_reg.status[$past(i_err_bank)][ST_MODEL_MSB:ST_MODEL_LSB] == MS_HA_WDATA_PARITY;
   endproperty
   a_wdata_code: assert property (p_wdata_code) // RULE4
      else $error("write data parity code wrong");

   property p_patrol_corr_code; // RULE6
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_err_valid && i_err_kind == EV_PATROL_CORR)
         |=> state_reg.status[$past(i_err_bank)][ST_MODEL_MSB:ST_MODEL_LSB] == MS_PATROL_CORR;
   endproperty
   a_patrol_corr_code: assert property (p_patrol_corr_code) // RULE6
      else $error("corrected patrol code wrong");

   property p_spare_code; // RULE7
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_err_valid && i_err_kind == EV_SPARE_CORR)
         |=> state_reg.status[$past(i_err_bank)][ST_MODEL_MSB:ST_MODEL_LSB] == MS_SPARE_CORR;
   endproperty
   a_spare_code: assert property (p_spare_code) // RULE7
      else $error("corrected spare code wrong");

   property p_wdb_parity_code; // RULE8
      @(posedge i_core_clk) disable iff (!i_rst_n)
      (i_err_valid && i_err_kind == EV_WDB_PARITY)
         |=> state_reg.status[$past(i_err_bank)][ST_MODEL_MSB:ST_MODEL_LSB] == MS_WDB_PARITY;
   endproperty
   a_wdb_parity_code: assert property (p_wdb_parity_code) // RULE8
      else $error("buffer parity code wrong");

   property p_rd_pulse; // RULE1
      @(posedge i_core_clk) disable iff (!i_rst_n)
      i_rd_en |=> o_rd_valid;
   endproperty
   a_rd_pulse: assert property (p_rd_pulse) // RULE1
      else $error("read answer missing");
endmodule : mc_error_log

// ==== core/mc_error_log_pkg.sv ====
// Constants for the memory controller error-log bank set
package mc_error_log_pkg;
   localparam int unsigned BANK_COUNT = 8;
   localparam int unsigned FIRST_BANK_NUMBER = 9;
   localparam int unsigned LAST_BANK_NUMBER = 16;
   localparam int unsigned BANK_INDEX_WIDTH = 3;
   localparam int unsigned REG_WIDTH = 64;
   localparam int unsigned CTRL_EXT_LOG_BIT = 1;
   // Status field positions
   localparam int unsigned ST_CODE_LSB = 0;
   localparam int unsigned ST_CODE_MSB = 15;
   localparam int unsigned ST_MODEL_LSB = 16;
   localparam int unsigned ST_MODEL_MSB = 31;
   localparam int unsigned ST_DEV_LSB = 32;
   localparam int unsigned ST_DEV_MSB = 36;
   localparam int unsigned ST_RSVD_BIT = 37;
   localparam int unsigned ST_ARCH_LSB = 38;
   localparam int unsigned ST_ARCH_MSB = 56;
   localparam int unsigned ST_VALID_LSB = 57;
   localparam int unsigned ST_VALID_MSB = 63;
   // Misc field positions
   localparam int unsigned MI_ADDR_LSB = 0;
   localparam int unsigned MI_ADDR_MSB = 8;
   localparam int unsigned MI_ID_LSB = 9;
   localparam int unsigned MI_ID_MSB = 13;
   localparam int unsigned MI_MASK1_LSB = 14;
   localparam int unsigned MI_MASK1_MSB = 29;
   localparam int unsigned MI_MASK2_LSB = 30;
   localparam int unsigned MI_MASK2_MSB = 45;
   localparam int unsigned MI_RANK1_LSB = 46;
   localparam int unsigned MI_RANK1_MSB = 50;
   localparam int unsigned MI_RANK2_LSB = 51;
   localparam int unsigned MI_RANK2_MSB = 55;
   localparam int unsigned MI_RSVD_LSB = 56;
   localparam int unsigned MI_RSVD_MSB = 61;
   localparam int unsigned MI_VALID1_BIT = 62;
   localparam int unsigned MI_VALID2_BIT = 63;
   // Model-specific error encodings
   localparam logic [15:0] MS_ADDR_PARITY = 16'h0001;
   localparam logic [15:0] MS_HA_WDATA_PARITY = 16'h0002;
   localparam logic [15:0] MS_HA_WBE_PARITY = 16'h0004;
   localparam logic [15:0] MS_PATROL_CORR = 16'h0008;
   localparam logic [15:0] MS_PATROL_UNCORR = 16'h0010;
   localparam logic [15:0] MS_SPARE_CORR = 16'h0020;
   localparam logic [15:0] MS_SPARE_UNCORR = 16'h0040;
   localparam logic [15:0] MS_WDB_PARITY = 16'h0100;
   localparam logic [3:0] BUS_CODE_TOP = 4'h1;
   localparam logic [63:0] REG_RESET = 64'h0000000000000000;
   typedef enum logic [3:0] {
      EV_ADDR_PARITY,
      EV_HA_WDATA_PARITY,
      EV_HA_WBE_PARITY,
      EV_PATROL_CORR,
      EV_PATROL_UNCORR,
      EV_SPARE_CORR,
      EV_SPARE_UNCORR,
      EV_WDB_PARITY,
      EV_CORR_READ
   } err_kind_e;
endpackage : mc_error_log_pkg

// ==== tb/mc_error_log_tb.sv ====
// Self-checking bench for the memory controller error-log banks
module mc_error_log_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import mc_error_log_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [63:0] ctrl = 64'h0;
   logic err_valid = 1'b0;
   logic [2:0] err_bank = 3'h0;
   err_kind_e kind = EV_ADDR_PARITY;
   logic [1:0] pp = 2'h2;
   logic t = 1'b1;
   logic [3:0] rrrr = 4'h9;
   logic [1:0] ii = 2'h1;
   logic [1:0] ll = 2'h3;
   logic [8:0] addr = 9'h1A5;
   logic [18:0] arch = 19'h5A5A5;
   logic [6:0] vld = 7'h55;
   logic [4:0] dev = 5'h0A;
   logic [15:0] mask = 16'hA5C3;
   logic [4:0] rank = 5'h11;
   logic [4:0] write_data_buffer = 5'h13;
   logic rd_en = 1'b0;
   logic [4:0] rd_index = 5'h0;
   logic clr_en = 1'b0;
   logic [2:0] clr_bank = 3'h0;
   logic [63:0] rd_data;
   logic rd_valid;
   int num_errors = 0;
   int tests_run = 0;
   logic [63:0] st;
   logic [63:0] mi;
   logic [15:0] code_exp [9] = '{16'h0001, 16'h0002, 16'h0004, 16'h0008, 16'h0010,
      16'h0020, 16'h0040, 16'h0100, 16'h0000};

   always #2.5 clk = ~clk;

   mc_error_log uut (.i_core_clk(clk), .i_rst_n(rst_n), .i_error_logging_control(ctrl),
      .i_err_valid(err_valid), .i_err_bank(err_bank), .i_err_kind(kind), .i_err_pp(pp),
      .i_err_t(t), .i_err_rrrr(rrrr), .i_err_ii(ii), .i_err_ll(ll), .i_err_addr_info(addr),
      .i_err_arch_info(arch), .i_err_validity(vld), .i_err_device(dev),
      .i_err_bit_mask(mask), .i_err_rank(rank), .i_err_wdb_id(write_data_buffer), .i_rd_en(rd_en),
      .i_rd_index(rd_index), .i_clr_en(clr_en), .i_clr_bank(clr_bank),
      .o_rd_data(rd_data), .o_rd_valid(rd_valid));

   task automatic chk(input string name, input logic [63:0] got, input logic [63:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic rd(input logic [4:0] idx, output logic [63:0] d);
      @(posedge clk);
      #1 rd_en = 1'b1;
      rd_index = idx;
      @(posedge clk);
      #1 rd_en = 1'b0;
      chk("read valid", {63'h0, rd_valid}, 64'h1);
      d = rd_data;
      @(posedge clk);
      #1 chk("read valid drop", {63'h0, rd_valid}, 64'h0);
   endtask : rd

   task automatic cap(input logic [2:0] b, input err_kind_e k);
      @(posedge clk);
      #1 err_valid = 1'b1;
      err_bank = b;
      kind = k;
      @(posedge clk);
      #1 err_valid = 1'b0;
   endtask : cap

   task automatic clr(input logic [2:0] b);
      @(posedge clk);
      #1 clr_en = 1'b1;
      clr_bank = b;
      @(posedge clk);
      #1 clr_en = 1'b0;
   endtask : clr

   task automatic t_reset();
      for (int b = 0; b < 8; b++)
      begin
         rd(5'(b), st);
         rd(5'(b + 16), mi);
         chk("reset status", st, REG_RESET);
         chk("reset misc", mi, REG_RESET);
      end
      rd(5'h08, st);
      chk("unmapped index", st, 64'h0);
   endtask : t_reset

   // Every kind once, extended logging off, spread over all eight banks
   task automatic t_codes();
      ctrl = 64'h0;
      for (int k = 0; k < 9; k++)
      begin
         cap(3'(k % 8), err_kind_e'(k));
         rd(5'(k % 8), st);
         rd(5'(k % 8 + 16), mi);
         chk("arch code", st[15:0], {3'h0, 1'b1, pp, t, rrrr, ii, ll});
         chk("model code", st[31:16], code_exp[k]);
         chk("device id off", st[37:32], 6'h0);
         chk("arch info", st[56:38], arch);
         chk("validity", st[63:57], vld);
         chk("addr info", mi[8:0], addr);
         chk("ext misc off", mi[63:14], 50'h0);
      end
   endtask : t_codes

   // First then second correctable read with extended logging on
   task automatic t_ext();
      ctrl = 64'h2;
      clr(3'h3);
      dev = 5'h0A;
      mask = 16'hA5C3;
      rank = 5'h11;
      cap(3'h3, EV_CORR_READ);
      rd(5'h03, st);
      rd(5'h13, mi);
      chk("first device", st[36:32], 5'h0A);
      chk("first mask", mi[29:14], 16'hA5C3);
      chk("first rank", mi[50:46], 5'h11);
      chk("flags after first", mi[63:62], 2'b01);
      dev = 5'h15;
      mask = 16'h3C5A;
      rank = 5'h0E;
      cap(3'h3, EV_CORR_READ);
      rd(5'h13, mi);
      chk("second mask", mi[45:30], 16'h3C5A);
      chk("second rank", mi[55:51], 5'h0E);
      chk("second device", mi[13:9], 5'h15);
      chk("first kept", mi[29:14], 16'hA5C3);
      chk("flags after second", mi[63:62], 2'b11);
      chk("first flag with second", {63'h0, mi[62]}, 64'h1);
      chk("misc reserved", mi[61:56], 6'h0);
      ctrl = 64'hFFFFFFFFFFFFFFFD;
      clr(3'h5);
      cap(3'h5, EV_CORR_READ);
      rd(5'h05, st);
      rd(5'h15, mi);
      chk("device id gated", st[36:32], 5'h0);
      chk("misc gated", mi[63:14], 50'h0);
   endtask : t_ext

   // Buffer entry id on both write parity kinds, then clearing
   task automatic t_wdb_clear();
      write_data_buffer = 5'h13;
      cap(3'h6, EV_HA_WDATA_PARITY);
      write_data_buffer = 5'h0C;
      cap(3'h7, EV_HA_WBE_PARITY);
      rd(5'h16, mi);
      chk("entry id data", mi[13:9], 5'h13);
      rd(5'h17, mi);
      chk("entry id enable", mi[13:9], 5'h0C);
      clr(3'h7);
      rd(5'h07, st);
      rd(5'h17, mi);
      chk("cleared status", st, 64'h0);
      chk("cleared misc", mi, 64'h0);
      rd(5'h16, mi);
      chk("neighbour kept", mi[13:9], 5'h13);
   endtask : t_wdb_clear

   // Clear and capture of one bank in one cycle: capture lands on a zeroed bank
   task automatic t_race();
      ctrl = 64'h2;
      dev = 5'h07;
      @(posedge clk);
      #1 err_valid = 1'b1;
      clr_en = 1'b1;
      err_bank = 3'h3;
      clr_bank = 3'h3;
      kind = EV_CORR_READ;
      @(posedge clk);
      #1 err_valid = 1'b0;
      clr_en = 1'b0;
      rd(5'h03, st);
      rd(5'h13, mi);
      chk("race device", st[36:32], 5'h07);
      chk("race flags", mi[63:62], 2'b01);
      chk("race second mask", mi[45:30], 16'h0);
   endtask : t_race

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done

   initial
   begin
      repeat (2) @(posedge clk);
      #1 rst_n = 1'b1;
      t_reset();
      t_codes();
      t_ext();
      t_wdb_clear();
      t_race();
      test_done();
   end

   // Whole run is under two hundred cycles
   initial
   begin
      #20000;
      num_errors++;
      test_done();
   end
endmodule : mc_error_log_tb
